/* File: design/vlan_filter_policy_pkg.sv */
// shared constants and types for the vlan filter policy register bank
package vlan_filter_policy_pkg;

  // register indices, byte address is four times the index
  localparam logic [7:0] IDX_PROTOCOL_CHECK = 8'h02; // vlan_protocol_check_ctrl
  localparam logic [7:0] IDX_UNTAG_DROP     = 8'h03; // untagged_drop_port_mask
  localparam logic [7:0] IDX_MEMBER_TAG     = 8'h05; // membership_and_tag_mode_ctrl
  localparam logic [7:0] IDX_GLOBAL_CFG     = 8'h08; // vlan enable, mgmt select, mgmt mode
  localparam logic [7:0] IDX_STATUS         = 8'h09; // read-only state

  // reset values
  localparam logic [7:0] RST_PROTOCOL_CHECK = 8'h10;
  localparam logic [8:0] RST_UNTAG_DROP     = 9'h000;
  localparam logic [7:0] RST_MEMBER_TAG     = 8'hC0;
  localparam logic [3:0] RST_GLOBAL_CFG     = 4'h0;

  // field positions in vlan_protocol_check_ctrl
  localparam int POS_GXRP_UNTAG_CHECK = 6;
  localparam int POS_GXRP_FWD_CHECK   = 5;
  localparam int POS_MGMT_FWD_BYPASS  = 2;

  // field positions in membership_and_tag_mode_ctrl
  localparam int POS_MEMBER_POLICY = 6; // two bits, 7:6
  localparam int POS_GVRP_TO_MGMT  = 5;
  localparam int POS_GMRP_TO_MGMT  = 4;
  localparam int POS_DT_SELECT     = 2; // two bits, 3:2
  localparam int POS_RSV_FLOOD     = 1;

  // field positions in the global config register
  localparam int POS_VLAN_ENABLE = 0;
  localparam int POS_MGMT_SELECT = 1; // two bits, 2:1
  localparam int POS_MGMT_MODE   = 3;

  // untagged drop mask layout
  localparam int POS_MGMT_PORT_MASK = 8;
  localparam int DATA_PORTS         = 6;

  // ingress port code of the inband management port
  localparam logic [3:0] PORT_INBAND_MGMT = 4'h8;
  localparam logic [3:0] PORT_DUAL_MGMT   = 4'h5;
  localparam logic [1:0] MGMT_SEL_DUAL    = 2'h3;

  // double tag select codes
  localparam logic [1:0] DT_SEL_OFF = 2'h0;
  localparam logic [1:0] DT_SEL_ON  = 2'h1;

  // reserved group address: prefix and low byte range
  localparam logic [39:0] RSV_GROUP_PREFIX = 40'h0180C20000;
  localparam logic [7:0]  RSV_GROUP_FIRST  = 8'h00;
  localparam logic [7:0]  RSV_GROUP_LOW    = 8'h02;
  localparam logic [7:0]  RSV_GROUP_HIGH   = 8'h2F;

  // source membership failure policy
  typedef enum logic [1:0] {
    MEMBER_FWD_NOLEARN = 2'b00,
    MEMBER_DROP        = 2'b01,
    MEMBER_FWD_LEARN   = 2'b10,
    MEMBER_TRAP_MGMT   = 2'b11
  } member_policy_type;

endpackage

/* File: design/policy_if.sv */
// carrier of live policy settings from the register bank to the decision logic
`timescale 1ns/1ps
`default_nettype none
interface policy_if;
  logic       gxrp_untag_check; // check gmrp/gvrp against untag map
  logic       gxrp_fwd_check;   // check gmrp/gvrp against forward map
  logic       mgmt_fwd_bypass;  // mgmt-port frames skip forward map
  logic [8:0] untag_drop_mask;  // per-port untagged drop
  logic [1:0] member_policy;    // membership failure action
  logic       gvrp_to_mgmt;     // copy gvrp to mgmt port
  logic       gmrp_to_mgmt;     // copy gmrp to mgmt port
  logic [1:0] dt_select;        // double tag select code
  logic       rsv_flood;        // reserved group flood
  logic       vlan_enable;      // 802.1q operation
  logic [1:0] mgmt_select;      // management port select
  logic       mgmt_mode;        // management mode
  modport owner (output gxrp_untag_check, gxrp_fwd_check, mgmt_fwd_bypass, untag_drop_mask,
                 member_policy, gvrp_to_mgmt, gmrp_to_mgmt, dt_select, rsv_flood,
                 vlan_enable, mgmt_select, mgmt_mode);
  modport user  (input gxrp_untag_check, gxrp_fwd_check, mgmt_fwd_bypass, untag_drop_mask,
                 member_policy, gvrp_to_mgmt, gmrp_to_mgmt, dt_select, rsv_flood,
                 vlan_enable, mgmt_select, mgmt_mode);
endinterface
`default_nettype wire

/* File: design/vlan_policy_decide.sv */
// combinational per-frame filtering decision from the live policy settings
`timescale 1ns/1ps
`default_nettype none
module vlan_policy_decide (
  policy_if.user     cfg,
  input  wire logic [3:0]  in_port,
  input  wire logic        in_tagged,
  input  wire logic        in_gvrp,
  input  wire logic        in_gmrp,
  input  wire logic [47:0] in_dmac,
  input  wire logic        in_vid_match,
  input  wire logic        in_src_member,
  output logic             dt_operation,
  output logic             do_fwd_check,
  output logic             do_untag_check,
  output logic             do_drop,
  output logic             do_to_mgmt,
  output logic             do_learn,
  output logic             do_flood_rsv
);

  // reserved group address test
  function automatic logic is_rsv_group(input logic [47:0] mac);
    logic [7:0] lo;
    lo = mac[7:0];
    is_rsv_group = (mac[47:8] == vlan_filter_policy_pkg::RSV_GROUP_PREFIX) &&
                   ((lo == vlan_filter_policy_pkg::RSV_GROUP_FIRST) ||
                    ((lo >= vlan_filter_policy_pkg::RSV_GROUP_LOW) &&
                     (lo <= vlan_filter_policy_pkg::RSV_GROUP_HIGH)));
  endfunction

  logic mgmt_src;   // frame entered on an inband management port
  logic map_active; // forward map checks live
  logic gxrp;       // gmrp or gvrp frame
  logic rsv;        // reserved group destination
  logic rsv_mode;   // flood bit has meaning
  logic member_bad; // membership test failed

  // decision, all paths assigned
  always_comb begin
    // reserved codes fall back to disabled: only 01 turns it on
    dt_operation = (cfg.dt_select == vlan_filter_policy_pkg::DT_SEL_ON);
    map_active   = cfg.vlan_enable | dt_operation;
    // port 5 counts as management only in dual mode
    mgmt_src = (in_port == vlan_filter_policy_pkg::PORT_INBAND_MGMT) ||
               ((in_port == vlan_filter_policy_pkg::PORT_DUAL_MGMT) &&
                (cfg.mgmt_select == vlan_filter_policy_pkg::MGMT_SEL_DUAL));
    gxrp     = in_gvrp | in_gmrp;
    rsv      = is_rsv_group(in_dmac);
    rsv_mode = dt_operation & cfg.mgmt_mode;
    do_untag_check = map_active & gxrp & cfg.gxrp_untag_check & ~mgmt_src;
    if (mgmt_src) begin
      do_fwd_check = map_active & ~cfg.mgmt_fwd_bypass;
    end else begin
      do_fwd_check = map_active & gxrp & cfg.gxrp_fwd_check;
    end
    member_bad = map_active & in_vid_match & ~in_src_member & ~mgmt_src;
    do_drop    = 1'b0;
    do_learn   = 1'b1;
    do_to_mgmt = (in_gvrp & cfg.gvrp_to_mgmt) | (in_gmrp & cfg.gmrp_to_mgmt);
    // ports 5..0 map one to one, management bit never drops
    if (!in_tagged && !mgmt_src && (in_port < 4'(vlan_filter_policy_pkg::DATA_PORTS)) &&
        cfg.untag_drop_mask[in_port]) begin
      do_drop = 1'b1;
    end
    if (member_bad) begin
      case (cfg.member_policy)
        vlan_filter_policy_pkg::MEMBER_FWD_NOLEARN: do_learn = 1'b0;
        vlan_filter_policy_pkg::MEMBER_DROP: begin
          do_drop  = 1'b1;
          do_learn = 1'b0;
        end
        vlan_filter_policy_pkg::MEMBER_FWD_LEARN: do_learn = 1'b1;
        vlan_filter_policy_pkg::MEMBER_TRAP_MGMT: begin
          do_learn   = 1'b0;
          do_to_mgmt = 1'b1;
        end
        default: do_learn = 1'b1;
      endcase
    end
    do_flood_rsv = 1'b0;
    if (rsv && rsv_mode) begin
      if (cfg.rsv_flood) begin
        do_flood_rsv = 1'b1;
      end else begin
        do_to_mgmt = 1'b1;
      end
    end
  end

endmodule
`default_nettype wire

/* File: design/vlan_filter_policy_ctrl.sv */
// apb register bank for vlan filter policy with registered per-frame decisions
//
// The APB interface to the registers was decided locally.
`timescale 1ns/1ps
`default_nettype none
module vlan_filter_policy_ctrl (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        frame_valid,
  input  wire logic [3:0]  frame_port,
  input  wire logic        frame_tagged,
  input  wire logic        frame_gvrp,
  input  wire logic        frame_gmrp,
  input  wire logic [47:0] frame_dmac,
  input  wire logic        frame_vid_match,
  input  wire logic        frame_src_member,
  output logic             result_valid,
  output logic             result_drop,
  output logic             result_to_mgmt,
  output logic             result_learn,
  output logic             result_flood_rsv,
  output logic             result_fwd_check,
  output logic             result_untag_check,
  output logic             double_tag_operation
);

  policy_if cfg ();

  logic [7:0] protocol_check_q; // vlan_protocol_check_ctrl
  logic [8:0] untag_drop_q;     // untagged_drop_mask field
  logic [7:0] member_tag_q;     // membership_and_tag_mode_ctrl
  logic [3:0] global_cfg_q;     // enable, select, mgmt mode
  logic [7:0] drop_count_q;     // wrapping dropped-frame count
  logic [31:0] prdata_q;        // read data
  logic        pready_q;        // access completes
  logic        pslverr_q;       // unmapped address
  logic        access;          // access phase, answer due next cycle
  logic        wr_fire;         // write lands this edge
  logic [7:0]  idx;             // word index
  logic        mapped;          // index decodes

  // decision wires
  logic d_dt, d_fwd, d_untag, d_drop, d_mgmt, d_learn, d_flood;

  // settings fan out through the carrier
  assign cfg.gxrp_untag_check = protocol_check_q[vlan_filter_policy_pkg::POS_GXRP_UNTAG_CHECK];
  assign cfg.gxrp_fwd_check   = protocol_check_q[vlan_filter_policy_pkg::POS_GXRP_FWD_CHECK];
  assign cfg.mgmt_fwd_bypass  = protocol_check_q[vlan_filter_policy_pkg::POS_MGMT_FWD_BYPASS];
  assign cfg.untag_drop_mask  = untag_drop_q;
  assign cfg.member_policy    = member_tag_q[vlan_filter_policy_pkg::POS_MEMBER_POLICY +: 2];
  assign cfg.gvrp_to_mgmt     = member_tag_q[vlan_filter_policy_pkg::POS_GVRP_TO_MGMT];
  assign cfg.gmrp_to_mgmt     = member_tag_q[vlan_filter_policy_pkg::POS_GMRP_TO_MGMT];
  assign cfg.dt_select        = member_tag_q[vlan_filter_policy_pkg::POS_DT_SELECT +: 2];
  assign cfg.rsv_flood        = member_tag_q[vlan_filter_policy_pkg::POS_RSV_FLOOD];
  assign cfg.vlan_enable      = global_cfg_q[vlan_filter_policy_pkg::POS_VLAN_ENABLE];
  assign cfg.mgmt_select      = global_cfg_q[vlan_filter_policy_pkg::POS_MGMT_SELECT +: 2];
  assign cfg.mgmt_mode        = global_cfg_q[vlan_filter_policy_pkg::POS_MGMT_MODE];

  // index decode, feeds the error path and through it the write gate
  function automatic logic is_mapped(input logic [7:0] i);
    is_mapped = (i == vlan_filter_policy_pkg::IDX_PROTOCOL_CHECK) ||
                (i == vlan_filter_policy_pkg::IDX_UNTAG_DROP) ||
                (i == vlan_filter_policy_pkg::IDX_MEMBER_TAG) ||
                (i == vlan_filter_policy_pkg::IDX_GLOBAL_CFG) ||
                (i == vlan_filter_policy_pkg::IDX_STATUS);
  endfunction

  // one wait state: pready rises the cycle after penable
  assign idx     = paddr[9:2];
  assign mapped  = is_mapped(idx) && (paddr[1:0] == 2'h0) && (paddr[11:10] == 2'h0);
  assign access  = psel & penable & ~pready_q;
  assign wr_fire = psel & penable & pready_q & pwrite & ~pslverr_q;

  vlan_policy_decide u_decide (
    .cfg            (cfg),
    .in_port        (frame_port),
    .in_tagged      (frame_tagged),
    .in_gvrp        (frame_gvrp),
    .in_gmrp        (frame_gmrp),
    .in_dmac        (frame_dmac),
    .in_vid_match   (frame_vid_match),
    .in_src_member  (frame_src_member),
    .dt_operation   (d_dt),
    .do_fwd_check   (d_fwd),
    .do_untag_check (d_untag),
    .do_drop        (d_drop),
    .do_to_mgmt     (d_mgmt),
    .do_learn       (d_learn),
    .do_flood_rsv   (d_flood)
  );

  // apb handshake and read data
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h00000000;
    end else begin
      pready_q  <= access;
      pslverr_q <= access & ~mapped;
      if (access && !pwrite) begin
        case (idx)
          vlan_filter_policy_pkg::IDX_PROTOCOL_CHECK: prdata_q <= {24'h000000, protocol_check_q};
          // bits 31:9 read zero
          vlan_filter_policy_pkg::IDX_UNTAG_DROP: prdata_q <= {23'h000000, untag_drop_q};
          vlan_filter_policy_pkg::IDX_MEMBER_TAG: prdata_q <= {24'h000000, member_tag_q};
          vlan_filter_policy_pkg::IDX_GLOBAL_CFG: prdata_q <= {28'h0000000, global_cfg_q};
          vlan_filter_policy_pkg::IDX_STATUS: begin
            prdata_q <= {16'h0000, drop_count_q, 6'h00, d_fwd_active(), d_dt};
          end
          default: prdata_q <= 32'h00000000;
        endcase
      end else if (access) begin
        prdata_q <= 32'h00000000;
      end
    end
  end

  // live forward-check enable for status
  function automatic logic d_fwd_active();
    d_fwd_active = cfg.vlan_enable | d_dt;
  endfunction

  // register writes, byte lane 0 and 1 only matter
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      protocol_check_q <= vlan_filter_policy_pkg::RST_PROTOCOL_CHECK;
      untag_drop_q     <= vlan_filter_policy_pkg::RST_UNTAG_DROP;
      member_tag_q     <= vlan_filter_policy_pkg::RST_MEMBER_TAG;
      global_cfg_q     <= vlan_filter_policy_pkg::RST_GLOBAL_CFG;
    end else if (wr_fire) begin
      case (idx)
        vlan_filter_policy_pkg::IDX_PROTOCOL_CHECK: begin
          if (pstrb[0]) protocol_check_q <= pwdata[7:0];
        end
        vlan_filter_policy_pkg::IDX_UNTAG_DROP: begin
          if (pstrb[0]) untag_drop_q[7:0] <= pwdata[7:0];
          if (pstrb[1]) untag_drop_q[8] <= pwdata[vlan_filter_policy_pkg::POS_MGMT_PORT_MASK];
        end
        vlan_filter_policy_pkg::IDX_MEMBER_TAG: begin
          // reserved select codes are stored but act as off
          if (pstrb[0]) member_tag_q <= pwdata[7:0];
        end
        vlan_filter_policy_pkg::IDX_GLOBAL_CFG: begin
          if (pstrb[0]) global_cfg_q <= pwdata[3:0];
        end
        default: global_cfg_q <= global_cfg_q;
      endcase
    end
  end

  // per-frame result, one cycle after frame_valid
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      result_valid       <= 1'b0;
      result_drop        <= 1'b0;
      result_to_mgmt     <= 1'b0;
      result_learn       <= 1'b0;
      result_flood_rsv   <= 1'b0;
      result_fwd_check   <= 1'b0;
      result_untag_check <= 1'b0;
    end else begin
      result_valid       <= frame_valid;
      result_drop        <= frame_valid & d_drop;
      result_to_mgmt     <= frame_valid & d_mgmt;
      result_learn       <= frame_valid & d_learn;
      result_flood_rsv   <= frame_valid & d_flood;
      result_fwd_check   <= frame_valid & d_fwd;
      result_untag_check <= frame_valid & d_untag;
    end
  end

  // status: effective double tag and drop count
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      double_tag_operation <= 1'b0;
      drop_count_q         <= 8'h00;
    end else begin
      double_tag_operation <= d_dt;
      if (frame_valid && d_drop) begin
        drop_count_q <= drop_count_q + 8'h01;
      end
    end
  end

  assign prdata  = prdata_q;
  assign pready  = pready_q;
  assign pslverr = pslverr_q;

  // checks on the frame decision path and the apb handshake
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  logic mgmt_in; // helper: frame from a management port
  assign mgmt_in = (frame_port == vlan_filter_policy_pkg::PORT_INBAND_MGMT) ||
                   ((frame_port == vlan_filter_policy_pkg::PORT_DUAL_MGMT) &&
                    (cfg.mgmt_select == vlan_filter_policy_pkg::MGMT_SEL_DUAL));

  property p_untag_gxrp;
    frame_valid & (frame_gvrp | frame_gmrp) & ~mgmt_in & ~cfg.gxrp_untag_check
      |=> !result_untag_check;
  endproperty
  a_untag_gxrp: assert property (p_untag_gxrp) else $error("untag check not gated");

  property p_fwd_gxrp;
    frame_valid & (frame_gvrp | frame_gmrp) & ~mgmt_in & cfg.gxrp_fwd_check & cfg.vlan_enable
      |=> result_fwd_check;
  endproperty
  a_fwd_gxrp: assert property (p_fwd_gxrp) else $error("gxrp forward check missing");

  property p_mgmt_bypass;
    frame_valid & mgmt_in & cfg.mgmt_fwd_bypass |=> !result_fwd_check;
  endproperty
  a_mgmt_bypass: assert property (p_mgmt_bypass) else $error("bypass ignored");

  property p_dt_enables;
    frame_valid & mgmt_in & ~cfg.mgmt_fwd_bypass & ~cfg.vlan_enable &
      (cfg.dt_select == vlan_filter_policy_pkg::DT_SEL_ON) |=> result_fwd_check;
  endproperty
  a_dt_enables: assert property (p_dt_enables) else $error("dt does not enable check");

  property p_untag_drop;
    frame_valid & ~frame_tagged & ~mgmt_in & (frame_port < 4'h6) &
      untag_drop_q[frame_port] |=> result_drop && result_valid;
  endproperty
  a_untag_drop: assert property (p_untag_drop) else $error("untagged frame kept");

  // neither the untagged mask nor the membership policy may drop a management frame
  property p_mgmt_no_drop;
    frame_valid & mgmt_in |=> !result_drop;
  endproperty
  a_mgmt_no_drop: assert property (p_mgmt_no_drop) else $error("mgmt frame dropped");

  // port 5 in dual mode is never subject to the membership policy
  property p_dual_no_member;
    frame_valid & (frame_port == vlan_filter_policy_pkg::PORT_DUAL_MGMT) &
      (cfg.mgmt_select == vlan_filter_policy_pkg::MGMT_SEL_DUAL) |=> result_learn;
  endproperty
  a_dual_no_member: assert property (p_dual_no_member) else $error("dual mgmt policed");

  property p_member_drop;
    frame_valid & cfg.vlan_enable & frame_vid_match & ~frame_src_member & ~mgmt_in &
      (cfg.member_policy == 2'b01) |=> result_drop && !result_learn;
  endproperty
  a_member_drop: assert property (p_member_drop) else $error("member policy drop");

  property p_rsv_dt;
    (member_tag_q[3:2] != vlan_filter_policy_pkg::DT_SEL_ON) ##1 1'b1 |-> !double_tag_operation;
  endproperty
  a_rsv_dt: assert property (p_rsv_dt) else $error("dt active off code");

  property p_gvrp_mgmt;
    frame_valid & frame_gvrp & cfg.gvrp_to_mgmt |=> result_to_mgmt;
  endproperty
  a_gvrp_mgmt: assert property (p_gvrp_mgmt) else $error("gvrp not to mgmt");

  property p_flood_gate;
    frame_valid & ~cfg.mgmt_mode |=> !result_flood_rsv;
  endproperty
  a_flood_gate: assert property (p_flood_gate) else $error("flood outside mode");

  // top end of the reserved range must still trap with flood clear
  property p_rsv_trap;
    frame_valid & (frame_dmac[47:8] == vlan_filter_policy_pkg::RSV_GROUP_PREFIX) &
      (frame_dmac[7:0] == vlan_filter_policy_pkg::RSV_GROUP_HIGH) & cfg.mgmt_mode &
      (cfg.dt_select == vlan_filter_policy_pkg::DT_SEL_ON) & ~cfg.rsv_flood
      |=> result_to_mgmt;
  endproperty
  a_rsv_trap: assert property (p_rsv_trap) else $error("reserved group not trapped");

  property p_apb_wait;
    psel & penable & ~pready |=> pready;
  endproperty
  a_apb_wait: assert property (p_apb_wait) else $error("apb answer late");

  c_drop: cover property (result_valid && result_drop);
  c_flood: cover property (result_valid && result_flood_rsv);
  c_trap: cover property (result_valid && result_to_mgmt && !result_drop);
  c_wr: cover property (wr_fire);
  c_dt_on: cover property (double_tag_operation && result_valid);

endmodule
`default_nettype wire

/* File: dv/vlan_filter_policy_ctrl_tb_top.sv */
// self-checking bench for the vlan filter policy register bank
`timescale 1ns/1ps
`default_nettype none
module vlan_filter_policy_ctrl_tb_top;
  // one table row: config words, frame fields, expected results and which bits matter
  typedef struct packed {
    logic [7:0] c2;   // protocol check control
    logic [8:0] m;    // untagged drop mask
    logic [7:0] c5;   // membership and tag mode control
    logic [3:0] g;    // global config
    logic [3:0] port; // ingress port code
    logic [2:0] f;    // tagged, gvrp, gmrp
    logic [7:0] dlo;  // low byte of destination, prefix is the reserved group one
    logic       mem;  // source is a member
    logic [5:0] exp;  // drop, to_mgmt, learn, flood, fwd, untag
    logic [5:0] care; // only these bits are compared, the rest are left open
  } row_type;

  logic        pclk, presetn, psel, penable, pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0]  pstrb, frame_port;
  logic        pready, pslverr, er, frame_valid, frame_tagged, frame_gvrp, frame_gmrp;
  logic [47:0] frame_dmac;
  logic        frame_vid_match, frame_src_member, result_valid, result_drop, result_to_mgmt;
  logic        result_learn, result_flood_rsv, result_fwd_check, result_untag_check;
  logic        double_tag_operation;
  int          errors, compares, cycles;
  row_type     rows [25] = '{
    '{8'h60, 9'h000, 8'h00, 4'h1, 4'h1, 3'h6, 8'h40, 1'h1, 6'h0B, 6'h3F},
    '{8'h20, 9'h000, 8'h00, 4'h1, 4'h2, 3'h5, 8'h40, 1'h1, 6'h0A, 6'h3F},
    '{8'h40, 9'h000, 8'h00, 4'h1, 4'h0, 3'h5, 8'h40, 1'h1, 6'h09, 6'h3F},
    '{8'h60, 9'h000, 8'h00, 4'h0, 4'h1, 3'h6, 8'h40, 1'h1, 6'h00, 6'h37},
    '{8'h64, 9'h000, 8'h00, 4'h1, 4'h8, 3'h6, 8'h40, 1'h1, 6'h00, 6'h37},
    '{8'h00, 9'h13F, 8'h00, 4'h1, 4'h3, 3'h0, 8'h40, 1'h1, 6'h20, 6'h30},
    '{8'h00, 9'h13F, 8'h00, 4'h1, 4'h8, 3'h0, 8'h40, 1'h1, 6'h00, 6'h30},
    '{8'h00, 9'h13F, 8'h00, 4'h7, 4'h5, 3'h0, 8'h40, 1'h1, 6'h00, 6'h30},
    '{8'h00, 9'h020, 8'h00, 4'h1, 4'h5, 3'h0, 8'h40, 1'h1, 6'h20, 6'h30},
    '{8'h00, 9'h020, 8'h00, 4'h1, 4'h4, 3'h0, 8'h40, 1'h1, 6'h00, 6'h30},
    '{8'h00, 9'h000, 8'h40, 4'h1, 4'h1, 3'h4, 8'h40, 1'h0, 6'h20, 6'h30},
    '{8'h00, 9'h000, 8'h40, 4'h1, 4'h1, 3'h4, 8'h40, 1'h1, 6'h08, 6'h38},
    '{8'h00, 9'h000, 8'h00, 4'h1, 4'h1, 3'h4, 8'h40, 1'h0, 6'h00, 6'h38},
    '{8'h00, 9'h000, 8'h80, 4'h1, 4'h1, 3'h4, 8'h40, 1'h0, 6'h08, 6'h38},
    '{8'h00, 9'h000, 8'hC0, 4'h1, 4'h1, 3'h4, 8'h40, 1'h0, 6'h10, 6'h38},
    '{8'h00, 9'h000, 8'h40, 4'h1, 4'h8, 3'h4, 8'h40, 1'h0, 6'h00, 6'h30},
    '{8'h00, 9'h000, 8'h20, 4'h1, 4'h1, 3'h6, 8'h40, 1'h1, 6'h18, 6'h3F},
    '{8'h00, 9'h000, 8'h10, 4'h1, 4'h1, 3'h6, 8'h40, 1'h1, 6'h08, 6'h3F},
    '{8'h00, 9'h000, 8'h10, 4'h1, 4'h1, 3'h5, 8'h40, 1'h1, 6'h18, 6'h3F},
    '{8'h00, 9'h000, 8'h06, 4'h9, 4'h1, 3'h4, 8'h02, 1'h1, 6'h04, 6'h34},
    '{8'h00, 9'h000, 8'h04, 4'h9, 4'h1, 3'h4, 8'h2F, 1'h1, 6'h10, 6'h34},
    '{8'h00, 9'h000, 8'h04, 4'h9, 4'h1, 3'h4, 8'h01, 1'h1, 6'h00, 6'h34},
    '{8'h00, 9'h000, 8'h04, 4'h1, 4'h1, 3'h4, 8'h00, 1'h1, 6'h00, 6'h34},
    '{8'h00, 9'h000, 8'h0C, 4'h9, 4'h1, 3'h4, 8'h00, 1'h1, 6'h00, 6'h34},
    '{8'h00, 9'h000, 8'h04, 4'h9, 4'h1, 3'h4, 8'h00, 1'h1, 6'h10, 6'h34}
  };

  vlan_filter_policy_ctrl uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .frame_valid(frame_valid), .frame_port(frame_port),
    .frame_tagged(frame_tagged), .frame_gvrp(frame_gvrp), .frame_gmrp(frame_gmrp),
    .frame_dmac(frame_dmac), .frame_vid_match(frame_vid_match),
    .frame_src_member(frame_src_member), .result_valid(result_valid),
    .result_drop(result_drop), .result_to_mgmt(result_to_mgmt), .result_learn(result_learn),
    .result_flood_rsv(result_flood_rsv), .result_fwd_check(result_fwd_check),
    .result_untag_check(result_untag_check), .double_tag_operation(double_tag_operation));

  // 10 MHz clock
  always #50 pclk = ~pclk;

  // hang guard: the whole run needs well under a thousand cycles
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 5000) begin
      errors++;
      finish_test();
    end
  end

  task automatic finish_test();
    $display("checks %0d mismatches %0d", compares, errors);
    if (errors == 0 && compares > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    compares++;
    if (s !== e) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", nm, e, s);
    end
  endtask

  // one apb transfer; request held until pready is seen high at a rising edge
  task automatic apb(input logic w, input logic [7:0] idx, input logic [31:0] wd);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= {2'h0, idx, 2'h0};
    pwdata  <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rdchk(input logic [7:0] idx, input logic [31:0] e, input string nm);
    apb(1'b0, idx, 32'h0);
    chk(nm, e, rd);
    chk("pslverr", 32'h0, {31'h0, er});
  endtask

  // config through apb, then one frame, results looked at in their one valid cycle
  task automatic run_row(input row_type r);
    logic [5:0] res;
    apb(1'b1, vlan_filter_policy_pkg::IDX_PROTOCOL_CHECK, {24'h0, r.c2});
    apb(1'b1, vlan_filter_policy_pkg::IDX_UNTAG_DROP, {23'h0, r.m});
    apb(1'b1, vlan_filter_policy_pkg::IDX_MEMBER_TAG, {24'h0, r.c5});
    apb(1'b1, vlan_filter_policy_pkg::IDX_GLOBAL_CFG, {28'h0, r.g});
    @(posedge pclk);
    frame_valid <= 1'b1;
    frame_port  <= r.port;
    {frame_tagged, frame_gvrp, frame_gmrp} <= r.f;
    frame_dmac  <= {vlan_filter_policy_pkg::RSV_GROUP_PREFIX, r.dlo};
    frame_src_member <= r.mem;
    @(posedge pclk);
    frame_valid <= 1'b0;
    @(negedge pclk);
    res = {result_drop, result_to_mgmt, result_learn, result_flood_rsv, result_fwd_check,
           result_untag_check};
    chk("result_valid", 32'h1, {31'h0, result_valid});
    chk("results", {26'h0, r.exp & r.care}, {26'h0, res & r.care});
  endtask

  initial begin
    {pclk, presetn, psel, penable, pwrite, frame_valid, frame_tagged} = '0;
    {frame_gvrp, frame_gmrp, frame_src_member, paddr, pwdata, frame_port, frame_dmac} = '0;
    pstrb = 4'hF;
    frame_vid_match = 1'b1;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    rdchk(vlan_filter_policy_pkg::IDX_PROTOCOL_CHECK, 32'h10, "reg2 reset");
    rdchk(vlan_filter_policy_pkg::IDX_UNTAG_DROP, 32'h0, "reg3 reset");
    rdchk(vlan_filter_policy_pkg::IDX_MEMBER_TAG, 32'hC0, "reg5 reset");
    rdchk(vlan_filter_policy_pkg::IDX_GLOBAL_CFG, 32'h0, "cfg reset");
    $display("test reset values done");
    foreach (rows[i]) run_row(rows[i]);
    // a vid miss never fails membership, so the frame is kept and learns
    @(posedge pclk);
    frame_vid_match <= 1'b0;
    run_row(row_type'{8'h00, 9'h000, 8'h40, 4'h1, 4'h1, 3'h4, 8'h40, 1'h0, 6'h08, 6'h38});
    $display("test frame table done");
    // upper bits of the mask register are read-only zero
    apb(1'b1, vlan_filter_policy_pkg::IDX_UNTAG_DROP, 32'hFFFFFFFF);
    rdchk(vlan_filter_policy_pkg::IDX_UNTAG_DROP, 32'h1FF, "mask bits");
    // unmapped place refuses writes and reads back zero
    apb(1'b1, 8'h07, 32'hFFFFFFFF);
    chk("unmapped wr err", 32'h1, {31'h0, er});
    apb(1'b0, 8'h07, 32'h0);
    chk("unmapped rd err", 32'h1, {31'h0, er});
    chk("unmapped rd", 32'h0, rd);
    $display("test register access done");
    // reserved select code, then the enabling one
    apb(1'b1, vlan_filter_policy_pkg::IDX_MEMBER_TAG, 32'h0C);
    repeat (2) @(posedge pclk);
    chk("dt op reserved", 32'h0, {31'h0, double_tag_operation});
    apb(1'b0, vlan_filter_policy_pkg::IDX_STATUS, 32'h0);
    chk("status dt reserved", 32'h00000302, rd);
    apb(1'b1, vlan_filter_policy_pkg::IDX_MEMBER_TAG, 32'h04);
    repeat (2) @(posedge pclk);
    chk("dt op on", 32'h1, {31'h0, double_tag_operation});
    apb(1'b0, vlan_filter_policy_pkg::IDX_STATUS, 32'h0);
    chk("status dt on", 32'h00000303, rd);
    $display("test double tag select done");
    // second reset mid-run brings the defaults back
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(negedge pclk);
    chk("dt op after reset", 32'h0, {31'h0, double_tag_operation});
    rdchk(vlan_filter_policy_pkg::IDX_MEMBER_TAG, 32'hC0, "reg5 after reset");
    $display("test second reset done");
    finish_test();
  end
endmodule
`default_nettype wire
